// file: hdl/olr_pkg.sv
// Purpose : Constants for the oscillator and regulator override register group
// Assumes : Byte-wide registers at their printed addresses
// Notes   : Shared by the design and the bench
package olr_pkg;
  localparam logic [6:0] ADDR_XTAL_POR  = 7'h62;
  localparam logic [6:0] ADDR_RC_COARSE = 7'h63;
  localparam logic [6:0] ADDR_RC_FINE   = 7'h64;
  localparam logic [6:0] ADDR_LDO_CTRL  = 7'h65;
  localparam logic [6:0] ADDR_LDO_LVL   = 7'h66;

  localparam logic [4:0] RST_XTAL_LOW   = 5'h04;
  localparam logic [7:0] RST_RC_COARSE  = 8'h00;
  localparam logic [7:0] RST_RC_FINE    = 8'h00;
  localparam logic [7:0] RST_LDO_CTRL   = 8'h81;
  localparam logic [6:0] RST_LDO_LVL    = 7'h00;

  // Field positions
  localparam int PWST_LSB    = 5;
  localparam int CLKHYST_BIT = 4;
  localparam int BIAS2X_BIT  = 3;
  localparam int GAIN2X_BIT  = 2;
  localparam int BUFSEL_BIT  = 1;
  localparam int BUFEN_BIT   = 0;
  localparam int OVR_BIT     = 7;
  localparam int ENOVR_BIT   = 7;
  localparam int ENXTAL_BIT  = 6;
  localparam int ENTS_BIT    = 5;
  localparam int SLOW_RC_OSC_ENABLE_BIT  = 4;
  localparam int DIGPWDN_BIT = 0;

  typedef enum logic [2:0] {
    PWST_LOW  = 3'b000,
    PWST_RDY  = 3'b001,
    PWST_TUNE = 3'b011,
    PWST_TX   = 3'b010
  } olr_pwst_t;
endpackage

// file: hdl/olr_regs.sv
// Purpose : Oscillator/POR control, RC calibration override and regulator override registers
// Assumes : Serial interface logic delivers one-cycle read and write strobes on CLOCK
// Notes   : Read data is registered, valid the cycle after RD_STB
//
// Contract
// R1: Power state reported read-only in bits 7:5 with fixed distinct codes.
// R2: Buffer select 0 uses state machine; 1 uses software buffer-enable bit.
// R3: Coarse calibration reads internal result unless override set, then software value.
// R4: Fine calibration reads internal result unless override set, then software value.
// R5: Global override high forces on and off; low lets overrides only enable.
// R6: Oscillator control resets low five bits to 00100, only gain doubling set.
// R7: Coarse calibration register resets to all zero.
// R8: Regulator override register resets to 0x81.
// R9: Lowest regulator control bit powers down digital domain in idle.
// R10: Three-bit digital regulator level in bits 2:0; bit 3 reserved read-only.
// R11: Level register holds crystal, temperature sensor and slow RC enables.
// R12: Separate writable hysteresis, bias doubling and gain doubling bits 4, 3, 2.
// R13: Writes to read-only and reserved bits ignored; reserved bits read zero.
// R14: Software sets override bit and value in one byte write.
module olr_regs
  import olr_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic [6:0] ADDR,
  input  wire logic       WR_STB,
  input  wire logic [7:0] WR_DATA,
  input  wire logic       RD_STB,
  output logic      [7:0] RD_DATA,
  input  wire logic [2:0] PWR_STATE,
  input  wire logic       SM_BUF_EN,
  input  wire logic [6:0] CAL_COARSE,
  input  wire logic [6:0] CAL_FINE,
  input  wire logic [6:0] SM_LDO_EN,
  input  wire logic       SM_XTAL_EN,
  input  wire logic       IDLE,
  output logic            BUF_EN,
  output logic            CLK_HYST,
  output logic            DOUBLE_BIAS_ENABLE,
  output logic            DOUBLE_GAIN_ENABLE,
  output logic      [6:0] RC_COARSE,
  output logic      [6:0] RC_FINE,
  output logic            SMART_POR_EN,
  output logic      [5:0] LDO_EN,
  output logic            DIG_PWDN,
  output logic            XTAL_EN,
  output logic            TEMP_SENSOR_EN,
  output logic            SLOW_RC_OSC_ENABLE,
  output logic      [2:0] DIG_LEVEL
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [4:0] xtal_q;
  logic [7:0] coarse_q;
  logic [7:0] fine_q;
  logic [7:0] ldo_q;
  logic [6:0] lvl_q;   // bits 7:4 and 2:0, bit 3 not stored
  logic [7:0] rd_d;
  logic [5:0] ldo_d;
  logic [6:0] coarse_eff;
  logic [6:0] fine_eff;
  logic       xtal_d;
  logic       sel_xtal;
  logic       sel_coarse;
  logic       sel_fine;
  logic       sel_ldo;
  logic       sel_lvl;
  logic       wr_xtal;
  logic       wr_coarse;
  logic       wr_fine;
  logic       wr_ldo;
  logic       wr_lvl;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One compare per register keeps the write enables easy to audit
  assign sel_xtal   = (ADDR == ADDR_XTAL_POR);
  assign sel_coarse = (ADDR == ADDR_RC_COARSE);
  assign sel_fine   = (ADDR == ADDR_RC_FINE);
  assign sel_ldo    = (ADDR == ADDR_LDO_CTRL);
  assign sel_lvl    = (ADDR == ADDR_LDO_LVL);

  // Unmapped addresses raise no enable, so such writes vanish
  assign wr_xtal    = WR_STB & sel_xtal;                // R13
  assign wr_coarse  = WR_STB & sel_coarse;
  assign wr_fine    = WR_STB & sel_fine;
  assign wr_ldo     = WR_STB & sel_ldo;
  assign wr_lvl     = WR_STB & sel_lvl;                 // R13

  // Power state bits are not stored; reads take them live
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      xtal_q <= RST_XTAL_LOW;                          // R6
    end else if (wr_xtal) begin
      xtal_q <= WR_DATA[4:0];                          // R12 R13
    end
  end

  // Override bit and value land together from one byte
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      coarse_q <= RST_RC_COARSE;                       // R7
    end else if (wr_coarse) begin
      coarse_q <= WR_DATA;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      fine_q <= RST_RC_FINE;
    end else if (wr_fine) begin
      fine_q <= WR_DATA;
    end
  end

  // Reset leaves smart reset and idle powerdown armed
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ldo_q <= RST_LDO_CTRL;                           // R8
    end else if (wr_ldo) begin
      ldo_q <= WR_DATA;
    end
  end

  // Reserved bit 3 has no storage, so it can never read back as one
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      lvl_q <= RST_LDO_LVL;
    end else if (wr_lvl) begin
      lvl_q <= {WR_DATA[7:4], WR_DATA[2:0]};           // R10 R11 R13
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (ADDR)
      ADDR_XTAL_POR:  rd_d = {PWR_STATE, xtal_q};                    // R1
      ADDR_RC_COARSE: rd_d = {coarse_q[OVR_BIT],
                              coarse_q[OVR_BIT] ? coarse_q[6:0] : CAL_COARSE}; // R3
      ADDR_RC_FINE:   rd_d = {fine_q[OVR_BIT],
                              fine_q[OVR_BIT] ? fine_q[6:0] : CAL_FINE};       // R4
      ADDR_LDO_CTRL:  rd_d = ldo_q;
      ADDR_LDO_LVL:   rd_d = {lvl_q[6:3], 1'b0, lvl_q[2:0]};         // R13
      default:        rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RD_DATA <= 8'h00;
    end else if (RD_STB) begin
      RD_DATA <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // Every output is a flop: a write shows here two edges after its strobe.
  // Outputs sit low through reset and take the register values one edge later.

  // Stored calibration wins only while its override bit is set
  assign coarse_eff = coarse_q[OVR_BIT] ? coarse_q[6:0] : CAL_COARSE;   // R3
  assign fine_eff   = fine_q[OVR_BIT] ? fine_q[6:0] : CAL_FINE;         // R4

  // Global override set: software bits drive regulators both ways.
  // Clear: software can only add enables on top of the state machine.
  for (genvar gi = 0; gi < 6; gi++) begin : g_ldo_merge
    assign ldo_d[gi] = lvl_q[ENOVR_BIT - 1] ? ldo_q[gi + 1]
                                            : (ldo_q[gi + 1] | SM_LDO_EN[gi]);   // R5
  end

  assign xtal_d = lvl_q[ENOVR_BIT - 1] ? lvl_q[ENXTAL_BIT - 1]
                                       : (lvl_q[ENXTAL_BIT - 1] | SM_XTAL_EN);   // R5 R11

  // ----------------------------------------------------------------
  // Output buffer and oscillator trims
  // ----------------------------------------------------------------
  // Software enable bit is ignored unless the select bit hands it control
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      BUF_EN <= 1'b0;
    end else begin
      BUF_EN <= xtal_q[BUFSEL_BIT] ? xtal_q[BUFEN_BIT] : SM_BUF_EN;   // R2
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CLK_HYST <= 1'b0;
    end else begin
      CLK_HYST <= xtal_q[CLKHYST_BIT];                                // R12
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DOUBLE_BIAS_ENABLE <= 1'b0;
    end else begin
      DOUBLE_BIAS_ENABLE <= xtal_q[BIAS2X_BIT];                       // R12
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DOUBLE_GAIN_ENABLE <= 1'b0;
    end else begin
      DOUBLE_GAIN_ENABLE <= xtal_q[GAIN2X_BIT];                       // R12
    end
  end

  // ----------------------------------------------------------------
  // Calibration outputs
  // ----------------------------------------------------------------
  // Without override these follow the live result every cycle
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RC_COARSE <= 7'h00;
    end else begin
      RC_COARSE <= coarse_eff;                                        // R3
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RC_FINE <= 7'h00;
    end else begin
      RC_FINE <= fine_eff;                                            // R4
    end
  end

  // ----------------------------------------------------------------
  // Regulator control
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SMART_POR_EN <= 1'b0;
    end else begin
      SMART_POR_EN <= ldo_q[7];                                       // R8
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      LDO_EN <= 6'h00;
    end else begin
      LDO_EN <= ldo_d;                                                // R5
    end
  end

  // Enable alone does nothing; the domain drops only while idle
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DIG_PWDN <= 1'b0;
    end else begin
      DIG_PWDN <= ldo_q[DIGPWDN_BIT] & IDLE;                          // R9
    end
  end

  // ----------------------------------------------------------------
  // Level settings
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      XTAL_EN <= 1'b0;
    end else begin
      XTAL_EN <= xtal_d;                                              // R5 R11
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      TEMP_SENSOR_EN <= 1'b0;
    end else begin
      TEMP_SENSOR_EN <= lvl_q[ENTS_BIT - 1];                          // R11
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SLOW_RC_OSC_ENABLE <= 1'b0;
    end else begin
      SLOW_RC_OSC_ENABLE <= lvl_q[SLOW_RC_OSC_ENABLE_BIT - 1];                    // R11
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      DIG_LEVEL <= 3'h0;
    end else begin
      DIG_LEVEL <= lvl_q[2:0];                                        // R10
    end
  end

endmodule

// file: verification/olr_props.sv
// Purpose : Port-level checks for olr_regs
// Assumes : One clock, sync active-high reset
// Notes   : Watches a subset of the ports only
module olr_props
  import olr_pkg::*;
(
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic [6:0] ADDR,
  input wire logic       WR_STB,
  input wire logic [7:0] WR_DATA,
  input wire logic       RD_STB,
  input wire logic [7:0] RD_DATA,
  input wire logic [2:0] PWR_STATE,
  input wire logic [6:0] CAL_COARSE,
  input wire logic       IDLE,
  input wire logic       BUF_EN,
  input wire logic       DOUBLE_GAIN_ENABLE,
  input wire logic [6:0] RC_COARSE,
  input wire logic       SMART_POR_EN,
  input wire logic       DIG_PWDN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_pwst_read: assert property (RD_STB && ADDR == ADDR_XTAL_POR |=> RD_DATA[7:5] == $past(PWR_STATE))
    else $error("power state readback wrong");
  a_unmapped_zero: assert property (RD_STB && (ADDR < ADDR_XTAL_POR || ADDR > ADDR_LDO_LVL) |=> RD_DATA == 8'h00)
    else $error("unmapped read not zero");
  a_rsvd_zero: assert property (RD_STB && ADDR == ADDR_LDO_LVL |=> !RD_DATA[3])
    else $error("reserved bit reads one");
  a_pwdn_idle: assert property (DIG_PWDN |-> $past(IDLE))
    else $error("powerdown outside idle");
  a_reset_vals: assert property ($fell(RST) && !WR_STB |=> SMART_POR_EN && DOUBLE_GAIN_ENABLE)
    else $error("reset enables wrong");
  a_buf_select: assert property ((WR_STB && ADDR == ADDR_XTAL_POR && WR_DATA[1]) ##1
    !(WR_STB && ADDR == ADDR_XTAL_POR) |=> BUF_EN == $past(WR_DATA[0], 2))
    else $error("buffer enable not from software bit");
  a_coarse_int: assert property ((WR_STB && ADDR == ADDR_RC_COARSE && !WR_DATA[7]) ##1
    !(WR_STB && ADDR == ADDR_RC_COARSE) |=> RC_COARSE == $past(CAL_COARSE))
    else $error("coarse not internal");
  a_coarse_ovr: assert property ((WR_STB && ADDR == ADDR_RC_COARSE && WR_DATA[7]) ##1
    !(WR_STB && ADDR == ADDR_RC_COARSE) |=> RC_COARSE == $past(WR_DATA[6:0], 2))
    else $error("coarse override ignored");
endmodule
bind olr_regs olr_props olr_props_i (.*);

// file: verification/olr_regs_tb_top.sv
// Purpose : Self-checking bench for olr_regs
// Assumes : Inputs driven on the falling edge
// Notes   : Outputs settle two edges after a write
module olr_regs_tb_top import olr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 0, RST = 1, WR_STB = 0, RD_STB = 0, SM_BUF_EN = 0, SM_XTAL_EN = 0, IDLE = 0;
  logic [6:0] ADDR = 0, CAL_COARSE = 7'h2A, CAL_FINE = 7'h15, SM_LDO_EN = 0, RC_COARSE, RC_FINE;
  logic [7:0] WR_DATA = 0, RD_DATA;
  logic [2:0] PWR_STATE = 0, DIG_LEVEL;
  logic [5:0] LDO_EN;
  logic BUF_EN, CLK_HYST, DOUBLE_BIAS_ENABLE, DOUBLE_GAIN_ENABLE, SMART_POR_EN, DIG_PWDN, XTAL_EN;
  logic TEMP_SENSOR_EN, SLOW_RC_OSC_ENABLE;
  int fail_count = 0, checked = 0;
  olr_regs olr_regs_i (.*);
  initial forever #2.5 CLOCK = ~CLOCK;
  task automatic ck(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge CLOCK) {ADDR, WR_DATA, WR_STB} = {a, d, 1'b1};
    @(negedge CLOCK) WR_STB = 0;
    repeat (2) @(negedge CLOCK);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge CLOCK) {ADDR, RD_STB} = {a, 1'b1};
    @(negedge CLOCK) RD_STB = 0;
    ck(RD_DATA, e);
  endtask
  task automatic t_reset();
    rd(ADDR_XTAL_POR, 8'h04);
    rd(ADDR_RC_COARSE, {1'b0, CAL_COARSE});
    rd(ADDR_LDO_CTRL, 8'h81);
    ck({5'h00, SMART_POR_EN, DOUBLE_GAIN_ENABLE, DIG_PWDN}, 8'h06);
    $display("test reset done");
  endtask
  task automatic t_pwst();
    olr_pwst_t c[4] = '{PWST_LOW, PWST_RDY, PWST_TUNE, PWST_TX};
    for (int i = 0; i < 4; i++) begin
      PWR_STATE = c[i];
      rd(ADDR_XTAL_POR, {c[i], 5'h04});
    end
    $display("test power state done");
  endtask
  task automatic t_osc();
    SM_BUF_EN = 1;
    wr(ADDR_XTAL_POR, 8'hFD);
    rd(ADDR_XTAL_POR, {PWR_STATE, 5'h1D});
    ck({4'h0, BUF_EN, CLK_HYST, DOUBLE_BIAS_ENABLE, DOUBLE_GAIN_ENABLE}, 8'h0F);
    wr(ADDR_XTAL_POR, 8'h00);
    ck({7'h00, BUF_EN}, 8'h01);
    wr(ADDR_XTAL_POR, 8'h02);
    ck({7'h00, BUF_EN}, 8'h00);
    wr(7'h67, 8'hFF);
    rd(7'h67, 8'h00);
    rd(7'h61, 8'h00);
    $display("test oscillator done");
  endtask
  task automatic t_cal();
    wr(ADDR_RC_COARSE, 8'h85);
    rd(ADDR_RC_COARSE, 8'h85);
    wr(ADDR_RC_FINE, 8'hFF);
    ck({1'b0, RC_FINE}, 8'h7F);
    wr(ADDR_RC_FINE, 8'h7F);
    rd(ADDR_RC_FINE, {1'b0, CAL_FINE});
    wr(ADDR_RC_COARSE, 8'h00);
    ck({1'b0, RC_COARSE}, {1'b0, CAL_COARSE});
    $display("test calibration done");
  endtask
  task automatic t_ldo();
    SM_LDO_EN = 7'h7F;
    IDLE = 1;
    SM_XTAL_EN = 1;
    wr(ADDR_LDO_CTRL, 8'h01);
    ck({7'h00, XTAL_EN}, 8'h01);
    ck({2'b00, LDO_EN}, 8'h3F);
    ck({7'h00, DIG_PWDN}, 8'h01);
    wr(ADDR_LDO_LVL, 8'hFF);
    rd(ADDR_LDO_LVL, 8'hF7);
    ck({LDO_EN, 2'b00}, 8'h00);
    ck({2'b00, XTAL_EN, TEMP_SENSOR_EN, SLOW_RC_OSC_ENABLE, DIG_LEVEL}, 8'h3F);
    wr(ADDR_LDO_LVL, 8'h80);
    ck({7'h00, XTAL_EN}, 8'h00);
    $display("test regulator done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20us;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (20) @(negedge CLOCK);
    RST = 0;
    t_reset();
    t_pwst();
    t_osc();
    t_cal();
    t_ldo();
    give_verdict();
  end
endmodule
